// File: design/wfs_bank.sv
// Watchdog tap select, watchdog counter and read-clear fault status registers.
`timescale 1ns/1ps

module wfs_bank #(
    parameter int WD_TICK_CYC = wfs_pkg::WFS_WD_TICK_CYC
) (
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  arst_n,
    // Decoded register transfers from the serial frame logic
    input  wire wfs_pkg::wfs_reg_req_t reg_req,
    output logic [7:0]                 rd_data,
    output logic                       rd_hit,
    // Comparator outputs from the analog section, asynchronous
    input  wire wfs_pkg::wfs_chan_cond_t ch1_cond_raw,
    input  wire wfs_pkg::wfs_chan_cond_t ch2_cond_raw,
    input  wire logic                  therm_warn_raw,
    input  wire logic                  v5a_uv_raw,
    input  wire logic                  standalone_raw,
    // Watchdog and channel control outputs
    output logic                       wd_expired,
    output logic                       limp_home_enter,
    output logic [1:0]                 thermal_hold,
    output logic [1:0]                 chan_fault_summary
);
    import wfs_pkg::*;

    // One synchroniser bit per raw level: two channel structs plus three system levels.
    localparam int NSYNC = 2 * $bits(wfs_chan_cond_t) + 3;

    // Synchroniser stages for every analog condition.
    logic [NSYNC-1:0]   cond_meta_q;
    logic [NSYNC-1:0]   cond_sync_q;
    wfs_chan_cond_t     ch1_cond;
    wfs_chan_cond_t     ch2_cond;
    logic               tw_cond;
    logic               v5a_cond;
    logic               standalone_cond;

    // Register state.
    logic [3:0]         tap_sel_q;
    logic               wd_en_q;
    logic [7:0]         status_a_q;
    logic [5:0]         status_b_q;
    logic               v5a_uv_q;
    logic [1:0]         exp_cnt_q;
    logic               therm_warn_q;
    logic               pwr_cycle_q;

    // Read-clear bookkeeping.
    logic               clr_pend_q;
    logic [7:0]         clr_addr_q;
    logic [7:0]         clr_mask_q;
    logic               clr_now;
    logic [7:0]         clr_a;
    logic [7:0]         clr_b;
    logic [7:0]         clr_s;
    logic               clr_exp;

    // Watchdog state.
    logic [7:0]             tick_cnt_q;
    logic                   tick;
    logic [WFS_WD_WIDTH-1:0] wd_cnt_q;
    logic [4:0]             tap_bit;
    logic                   wd_timeout;
    logic                   wd_kick;

    // Access strobes and readback.
    logic               wr_stb;
    logic               rd_stb;
    logic [7:0]         status_a_val;
    logic [7:0]         status_b_val;
    logic [7:0]         status_s_val;
    logic [7:0]         read_val;
    logic               read_hit;

    // Maps a tap select code onto a counter bit index.
    // Below code eight only the low three bits count; every higher code saturates to the last tap.
    function automatic logic [4:0] wfs_tap_decode(input logic [3:0] code);
        logic [4:0] idx;
        idx = WFS_TAP_LAST;
        if (!code[3]) begin
            idx = WFS_TAP_FIRST + {2'b00, code[2:0]};
        end
        return idx;
    endfunction : wfs_tap_decode

    // True for every address this bank answers; a read elsewhere returns zero and no hit.
    function automatic logic wfs_addr_mapped(input logic [7:0] addr);
        logic hit;
        hit = 1'b0;
        if (addr == WFS_ADDR_SYS_CONFIG) begin
            hit = 1'b1;
        end
        if (addr >= WFS_ADDR_TAP_SELECT && addr <= WFS_ADDR_STATUS_SYS) begin
            hit = 1'b1;
        end
        return hit;
    endfunction : wfs_addr_mapped

    // Two flip-flop synchroniser; only the second stage is read by logic.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cond_meta_q <= '0;
            cond_sync_q <= '0;
        end else begin
            // Packing order here fixes the unpacking slices below.
            cond_meta_q <= {standalone_raw, v5a_uv_raw, therm_warn_raw,
                            ch2_cond_raw, ch1_cond_raw};
            cond_sync_q <= cond_meta_q;
        end
    end

    // Unpack the synchronised conditions.
    assign ch1_cond        = cond_sync_q[6:0];
    assign ch2_cond        = cond_sync_q[13:7];
    assign tw_cond         = cond_sync_q[14];
    assign v5a_cond        = cond_sync_q[15];
    assign standalone_cond = cond_sync_q[16];

    // Transfer strobes; requests count only on a valid transfer end.
    assign wr_stb = reg_req.xfer_end & reg_req.xfer_valid & reg_req.wr_cmd;
    assign rd_stb = reg_req.xfer_end & reg_req.xfer_valid & reg_req.rd_cmd;

    // Tap select register; the reserved upper nibble is not stored.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            tap_sel_q <= WFS_TAP_RESET;
        end else if (wr_stb && reg_req.addr == WFS_ADDR_TAP_SELECT) begin
            tap_sel_q <= reg_req.wdata[3:0];
        end
    end

    // Watchdog enable bit of the system configuration register.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wd_en_q <= WFS_WD_EN_RESET;
        end else if (wr_stb && reg_req.addr == WFS_ADDR_SYS_CONFIG) begin
            wd_en_q <= reg_req.wdata[WFS_WD_EN_BIT];
        end
    end

    // Prescaler gives the watchdog its tick rate as a one-cycle enable.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_cnt_q <= '0;
        end else if (tick) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 8'h01;
        end
    end
    assign tick = (tick_cnt_q >= 8'(WD_TICK_CYC - 1));

    // Timeout is the selected counter bit; any valid transfer restarts the count.
    assign tap_bit    = wfs_tap_decode(tap_sel_q);
    assign wd_timeout = wd_en_q & wd_cnt_q[tap_bit];
    assign wd_kick    = reg_req.xfer_end & reg_req.xfer_valid;

    // Watchdog counter; a disabled watchdog is held at zero so enabling starts a full period.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wd_cnt_q <= '0;
        end else if (!wd_en_q || wd_kick || wd_timeout) begin
            wd_cnt_q <= '0;
        end else if (tick) begin
            wd_cnt_q <= wd_cnt_q + 25'h0000001;
        end
    end

    // Expiry pulses out to the mode logic.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wd_expired      <= 1'b0;
            limp_home_enter <= 1'b0;
        end else begin
            wd_expired      <= wd_timeout;
            // A clear landing with the third expiry leaves the count at one, so there is no limp entry then.
            limp_home_enter <= wd_timeout && !clr_exp
                               && exp_cnt_q == (WFS_EXP_LIMP - 2'h1);
        end
    end

    // A read command captures which register and which set bits are to be cleared later.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            clr_pend_q <= 1'b0;
            clr_addr_q <= '0;
            clr_mask_q <= '0;
        end else if (reg_req.xfer_end) begin
            clr_pend_q <= rd_stb && read_hit;
            clr_addr_q <= reg_req.addr;
            clr_mask_q <= read_val;
        end
    end

    // The clear acts at the end of the response transfer, and only on bits that were reported.
    // An invalid transfer still closes the response frame, so a pending clear fires on it too.
    assign clr_now = clr_pend_q & reg_req.xfer_end;
    assign clr_a   = (clr_now && clr_addr_q == WFS_ADDR_STATUS_A)   ? clr_mask_q : 8'h00;
    assign clr_b   = (clr_now && clr_addr_q == WFS_ADDR_STATUS_B)   ? clr_mask_q : 8'h00;
    assign clr_s   = (clr_now && clr_addr_q == WFS_ADDR_STATUS_SYS) ? clr_mask_q : 8'h00;
    // The expiry count field is cleared as a whole whenever it was reported non-zero.
    assign clr_exp = (clr_s[WFS_SYS_EXP_LSB+1 -: 2] != 2'h0);

    // Status A: channel 2 upper nibble, channel 1 lower nibble; a live cause wins over the clear.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            status_a_q <= '0;
        end else begin
            status_a_q <= (status_a_q & ~clr_a) | {
                ch2_cond.low_side_limit, ch2_cond.high_side_limit,
                ch2_cond.output_short, ch2_cond.comp_overvoltage,
                ch1_cond.low_side_limit, ch1_cond.high_side_limit,
                ch1_cond.output_short, ch1_cond.comp_overvoltage};
        end
    end

    // Status B: thermal protection, bootstrap undervoltage, maximum duty per channel.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            status_b_q <= '0;
        end else begin
            status_b_q <= (status_b_q & ~clr_b[5:0]) | {
                ch2_cond.thermal_prot, ch2_cond.bootstrap_uv, ch2_cond.max_duty,
                ch1_cond.thermal_prot, ch1_cond.bootstrap_uv, ch1_cond.max_duty};
        end
    end

    // System status flags; the power-cycle flag has no cause after reset so one read clears it.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            v5a_uv_q     <= 1'b0;
            therm_warn_q <= 1'b0;
            pwr_cycle_q  <= WFS_PWR_CYCLE_RESET;
        end else begin
            v5a_uv_q     <= (v5a_uv_q & ~clr_s[WFS_SYS_V5A_UV]) | v5a_cond;
            therm_warn_q <= (therm_warn_q & ~clr_s[WFS_SYS_THERM_WRN]) | tw_cond;
            pwr_cycle_q  <= pwr_cycle_q & ~clr_s[WFS_SYS_PWR_CYCLE];
        end
    end

    // Expiry counter saturates at three; an expiry in the clearing cycle still counts.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            exp_cnt_q <= '0;
        end else if (wd_timeout) begin
            if (clr_exp) begin
                exp_cnt_q <= 2'h1;
            end else if (exp_cnt_q != WFS_EXP_LIMP) begin
                exp_cnt_q <= exp_cnt_q + 2'h1;
            end
        end else if (clr_exp) begin
            exp_cnt_q <= 2'h0;
        end
    end

    // Register views; summaries follow the latched channel flags, so they clear with them.
    assign status_a_val = status_a_q;
    assign status_b_val = {2'b00, status_b_q};
    always_comb begin
        status_s_val = 8'h00;
        status_s_val[WFS_SYS_STANDALONE]       = standalone_cond;
        status_s_val[WFS_SYS_V5A_UV]           = v5a_uv_q;
        status_s_val[WFS_SYS_EXP_LSB+1 -: 2]   = exp_cnt_q;
        status_s_val[WFS_SYS_THERM_WRN]        = therm_warn_q;
        status_s_val[WFS_SYS_PWR_CYCLE]        = pwr_cycle_q;
        status_s_val[WFS_SYS_CH2_SUM]          = |{status_a_q[7:4], status_b_q[5:3]};
        status_s_val[WFS_SYS_CH1_SUM]          = |{status_a_q[3:0], status_b_q[2:0]};
    end

    // Read multiplexer; the standalone bit is read-only and never cleared by a read.
    always_comb begin
        read_val = 8'h00;
        read_hit = 1'b1;
        case (reg_req.addr)
            WFS_ADDR_SYS_CONFIG: begin
                read_val[WFS_WD_EN_BIT] = wd_en_q;
                read_hit = 1'b0;
            end
            WFS_ADDR_TAP_SELECT: begin
                read_val = {4'h0, tap_sel_q};
                read_hit = 1'b0;
            end
            WFS_ADDR_STATUS_A: begin
                read_val = status_a_val;
            end
            WFS_ADDR_STATUS_B: begin
                read_val = status_b_val;
            end
            WFS_ADDR_STATUS_SYS: begin
                read_val = status_s_val & ~(8'h01 << WFS_SYS_STANDALONE);
            end
            default: begin
                read_hit = 1'b0;
            end
        endcase
    end

    // Response data is frozen at the end of the read command transfer for the next frame to shift out.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data <= '0;
            rd_hit  <= 1'b0;
        end else if (rd_stb) begin
            rd_data <= (reg_req.addr == WFS_ADDR_STATUS_SYS) ? status_s_val : read_val;
            rd_hit  <= wfs_addr_mapped(reg_req.addr);
        end
    end

    // A channel held by thermal protection may run again once its flag has been cleared.
    // The outputs trail the flags by one cycle, so a restart never precedes the clear.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            thermal_hold       <= '0;
            chan_fault_summary <= '0;
        end else begin
            thermal_hold       <= {status_b_q[5], status_b_q[2]};
            chan_fault_summary <= {status_s_val[WFS_SYS_CH2_SUM], status_s_val[WFS_SYS_CH1_SUM]};
        end
    end

endmodule : wfs_bank

// File: design/wfs_pkg.sv
// Package with register map, field layout, timing constants and carrier types of the watchdog and status bank.
package wfs_pkg;

    // Register byte addresses on the serial register port.
    localparam logic [7:0] WFS_ADDR_SYS_CONFIG = 8'h00;
    localparam logic [7:0] WFS_ADDR_TAP_SELECT = 8'h02;
    localparam logic [7:0] WFS_ADDR_STATUS_A   = 8'h03;
    localparam logic [7:0] WFS_ADDR_STATUS_B   = 8'h04;
    localparam logic [7:0] WFS_ADDR_STATUS_SYS = 8'h05;

    // Reset values.
    localparam logic [3:0] WFS_TAP_RESET       = 4'h8;
    localparam logic       WFS_WD_EN_RESET     = 1'b1;
    localparam logic       WFS_PWR_CYCLE_RESET = 1'b1;

    // Field positions.
    localparam int WFS_WD_EN_BIT     = 4;
    localparam int WFS_SYS_STANDALONE = 7;
    localparam int WFS_SYS_V5A_UV    = 6;
    localparam int WFS_SYS_EXP_LSB   = 4;
    localparam int WFS_SYS_THERM_WRN = 3;
    localparam int WFS_SYS_PWR_CYCLE = 2;
    localparam int WFS_SYS_CH2_SUM   = 1;
    localparam int WFS_SYS_CH1_SUM   = 0;

    // Watchdog geometry: first tap bit, last tap bit, counter width, expiry count for limp home.
    localparam int         WFS_WD_WIDTH     = 25;
    localparam logic [4:0] WFS_TAP_FIRST    = 5'h10;
    localparam logic [4:0] WFS_TAP_LAST     = 5'h18;
    localparam logic [1:0] WFS_EXP_LIMP     = 2'h3;

    // Timing: counter tick period and sys_clk period in ns.
    localparam int WFS_CLK_PERIOD_NS = 25;
    localparam int WFS_WD_TICK_NS    = 93;
    localparam int WFS_WD_TICK_CYC   = (WFS_WD_TICK_NS + WFS_CLK_PERIOD_NS - 1) / WFS_CLK_PERIOD_NS;

    // Live fault conditions of one channel, in status bit order.
    typedef struct packed {
        logic thermal_prot;
        logic bootstrap_uv;
        logic max_duty;
        logic low_side_limit;
        logic high_side_limit;
        logic output_short;
        logic comp_overvoltage;
    } wfs_chan_cond_t;

    // One decoded serial transfer, given at its end by the frame logic.
    typedef struct packed {
        logic       xfer_end;
        logic       xfer_valid;
        logic       rd_cmd;
        logic       wr_cmd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } wfs_reg_req_t;

endpackage : wfs_pkg

// File: dv/testbench.sv
// Self-checking bench for the watchdog tap and fault status bank.
`timescale 1ns/1ps
module testbench;
    import wfs_pkg::*;
    logic           sys_clk, arst_n, tw, uv, sa, rd_hit, wd_exp, limp;
    wfs_reg_req_t   req;
    wfs_chan_cond_t c1, c2;
    logic [7:0]     rd_data;
    logic [1:0]     th_hold, sums;
    logic [31:0]    seed;
    int             err_count, compares, ma, mb, mc, mtap, men, n;
    wfs_host_model wfs_host_model_i (.sys_clk(sys_clk), .reg_req(req));
    wfs_bank #(.WD_TICK_CYC(1)) wfs_bank_i (.sys_clk(sys_clk), .arst_n(arst_n), .reg_req(req),
        .rd_data(rd_data), .rd_hit(rd_hit), .ch1_cond_raw(c1), .ch2_cond_raw(c2), .therm_warn_raw(tw),
        .v5a_uv_raw(uv), .standalone_raw(sa), .wd_expired(wd_exp), .limp_home_enter(limp),
        .thermal_hold(th_hold), .chan_fault_summary(sums));
    initial sys_clk = 1'b0;
    always #12.5 sys_clk = ~sys_clk;
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Register image; summaries are the OR of a channel's latched flags.
    function automatic int model(input int a, input int live);
        int s1, s2;
        s1 = int'((ma & 15) != 0 || (mb & 7) != 0);
        s2 = int'((ma & 240) != 0 || (mb & 56) != 0);
        if (live) return a == 3 ? int'({c2[3:0], c1[3:0]}) : a == 4 ? int'({c2[6:4], c1[6:4]}) : 8 * tw + 64 * uv;
        case (a)
            0: return men * 16;
            2: return mtap;
            3: return ma;
            4: return mb;
            5: return mc | 128 * sa | 2 * s2 | s1;
            default: return 0;
        endcase
    endfunction : model
    // Read command, compare, then the response transfer that performs the clear.
    task automatic rd(input logic [7:0] a);
        seed = lfsr(seed);
        wfs_host_model_i.xfer(1'b1, 1'b0, a, 8'h00, 1'b1, int'(seed[1:0]));
        check(rd_data, 8'(model(a, 0)));
        check(8'(rd_hit), 8'(a == 0 || (a >= 2 && a <= 5)));
        check(8'(th_hold), 8'({mb[5], mb[2]}));
        wfs_host_model_i.xfer(1'b0, 1'b0, 8'h00, 8'h00, 1'b1, int'(seed[3:2]));
        if (a == 3) ma = ma & model(3, 1);
        if (a == 4) mb = mb & model(4, 1);
        if (a == 5) mc = mc & model(5, 1);
        repeat (3) @(negedge sys_clk);
        check(8'(th_hold), 8'({mb[5], mb[2]}));
        check(8'(sums), 8'(model(5, 0) & 3));
    endtask : rd
    // Apply live fault levels long enough to be latched.
    task automatic drive(input logic [31:0] r);
        @(negedge sys_clk);
        {sa, uv, tw, c2, c1} = r[16:0];
        repeat (5) @(negedge sys_clk);
        ma = ma | model(3, 1);
        mb = mb | model(4, 1);
        mc = mc | model(5, 1);
    endtask : drive
    task automatic print_verdict();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict
    // Watchdog: a hang counts as a mismatch.
    initial begin
        #(90000 * 25);
        err_count++;
        print_verdict();
    end
    initial begin
        {sa, uv, tw, c2, c1} = '0;
        // Reset image: tap code 8, watchdog enabled, power-cycle flag set.
        err_count = 0;
        compares  = 0;
        ma        = 0;
        mb        = 0;
        mtap      = 8;
        men       = 1;
        mc        = 4;
        arst_n    = 1'b0;
        seed = 32'h1b6599b3;
        repeat (12) @(negedge sys_clk);
        arst_n = 1'b1;
        for (int a = 0; a < 8; a++) rd(8'(a));
        rd(8'hc3);
        $display("test reset image done");
        // Every tap code, with noise in the read-only nibble, a status write and a refused write.
        for (int k = 0; k < 16; k++) begin
            seed = lfsr(seed);
            wfs_host_model_i.xfer(1'b0, 1'b1, WFS_ADDR_TAP_SELECT, {seed[7:4], 4'(k)}, 1'b1, 0);
            wfs_host_model_i.xfer(1'b0, 1'b1, WFS_ADDR_STATUS_A, seed[15:8], 1'b1, 0);
            wfs_host_model_i.xfer(1'b0, 1'b1, WFS_ADDR_TAP_SELECT, 8'h03, 1'b0, 0);
            mtap = k;
            rd(WFS_ADDR_TAP_SELECT);
        end
        wfs_host_model_i.xfer(1'b0, 1'b1, WFS_ADDR_SYS_CONFIG, 8'hef, 1'b1, 0);
        men = 0;
        rd(WFS_ADDR_SYS_CONFIG);
        wfs_host_model_i.xfer(1'b0, 1'b1, WFS_ADDR_SYS_CONFIG, 8'h10, 1'b1, 0);
        men = 1;
        $display("test tap codes done");
        // Random faults, some causes persisting through the read-clear.
        for (int k = 0; k < 8; k++) begin
            seed = lfsr(seed);
            drive(seed);
            drive(seed & lfsr(seed));
            for (int a = 3; a <= 5; a++) rd(8'(a));
        end
        drive(0);
        for (int a = 3; a <= 5; a++) rd(8'(a));
        $display("test fault flags done");
        // Shortest tap, left to expire once.
        wfs_host_model_i.xfer(1'b0, 1'b1, WFS_ADDR_TAP_SELECT, 8'h00, 1'b1, 0);
        mtap = 0;
        n = 0;
        while (wd_exp !== 1'b1 && n < 70000) begin
            @(negedge sys_clk);
            n++;
        end
        check(8'(n >= 65533 && n <= 65540), 8'h01);
        check(8'(limp), 8'h00);
        mc = mc | 16;
        rd(WFS_ADDR_STATUS_SYS);
        rd(WFS_ADDR_STATUS_SYS);
        $display("test watchdog expiry done");
        print_verdict();
    end
endmodule : testbench

// File: dv/wfs_bank_chk.sv
// Checker of watchdog timing, read responses and read-clear behaviour of the status bank.
`timescale 1ns/1ps
module wfs_bank_chk #(
    parameter int WD_TICK_CYC = 4
) (
    // Clock and reset
    input wire logic                    sys_clk,
    input wire logic                    arst_n,
    // Register port
    input wire wfs_pkg::wfs_reg_req_t   reg_req,
    input wire logic [7:0]              rd_data,
    input wire logic                    rd_hit,
    // Faults and watchdog
    input wire wfs_pkg::wfs_chan_cond_t ch1_cond_raw,
    input wire logic                    wd_expired,
    input wire logic                    limp_home_enter,
    input wire logic [1:0]              thermal_hold,
    input wire logic [1:0]              chan_fault_summary
);
    import wfs_pkg::*;
    logic [3:0]  tap_q;
    logic        en_q;
    logic [31:0] idle_q;
    logic [31:0] lo;
    logic        ok;
    logic        any1;
    // Codes above seven all use the top tap bit.
    assign ok   = reg_req.xfer_end && reg_req.xfer_valid;
    assign any1 = |ch1_cond_raw;
    assign lo   = (32'h1 << (tap_q[3] ? 24 : 16 + int'(tap_q[2:0]))) * WD_TICK_CYC;
    // Mirror of the tap and enable fields as last written.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            tap_q <= WFS_TAP_RESET;
            en_q  <= 1'b1;
        end else if (ok && reg_req.wr_cmd) begin
            if (reg_req.addr == WFS_ADDR_TAP_SELECT) tap_q <= reg_req.wdata[3:0];
            if (reg_req.addr == WFS_ADDR_SYS_CONFIG) en_q <= reg_req.wdata[WFS_WD_EN_BIT];
        end
    end
    // Idle cycles since the last kick; lags the real counter by a cycle after an expiry, hence the slack.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) idle_q <= '0;
        else if (ok || wd_expired || !en_q) idle_q <= '0;
        else idle_q <= idle_q + 32'h1;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    tap_lower_a: assert property (wd_expired |-> idle_q + 32'(3 * WD_TICK_CYC) >= lo)
        else $error("watchdog expired early");
    tap_upper_a: assert property (en_q |-> idle_q <= lo + 32'(3 * WD_TICK_CYC + 4))
        else $error("watchdog expired late");
    wd_enable_a: assert property (wd_expired |-> $past(en_q))
        else $error("expiry while disabled");
    wd_pulse_a: assert property (wd_expired |=> !wd_expired)
        else $error("expiry pulse too long");
    limp_pulse_a: assert property (limp_home_enter |-> wd_expired)
        else $error("limp entry without expiry");
    unmapped_rd_a: assert property (ok && reg_req.rd_cmd && reg_req.addr > 8'h05 |=> !rd_hit && rd_data == 8'h00)
        else $error("unmapped read answered");
    tap_read_a: assert property (ok && reg_req.rd_cmd && !reg_req.wr_cmd && reg_req.addr == 8'h02
        |=> rd_data == {4'h0, tap_q})
        else $error("tap readback wrong");
    resv_bits_a: assert property (ok && reg_req.rd_cmd && reg_req.addr == 8'h04 |=> rd_data[7:6] == 2'b00)
        else $error("reserved bits set");
    hold_clear_a: assert property ((|($past(thermal_hold) & ~thermal_hold))
        |-> $past(reg_req.xfer_end, 2) || $past(reg_req.xfer_end, 3)) else $error("thermal hold cleared early");
    sum_clear_a: assert property ((|($past(chan_fault_summary) & ~chan_fault_summary))
        |-> $past(reg_req.xfer_end, 2) || $past(reg_req.xfer_end, 3)) else $error("summary cleared early");
    sum_rise_a: assert property ($rose(chan_fault_summary[0])
        |-> $past(any1, 3) || $past(any1, 4) || $past(any1, 5)) else $error("summary set without cause");
endmodule : wfs_bank_chk

bind wfs_bank wfs_bank_chk #(.WD_TICK_CYC(WD_TICK_CYC)) wfs_bank_chk_i (.sys_clk(sys_clk), .arst_n(arst_n),
    .reg_req(reg_req), .rd_data(rd_data), .rd_hit(rd_hit), .ch1_cond_raw(ch1_cond_raw), .wd_expired(wd_expired),
    .limp_home_enter(limp_home_enter), .thermal_hold(thermal_hold), .chan_fault_summary(chan_fault_summary));

// File: dv/wfs_host_model.sv
// Model of the serial host that hands decoded register transfers to the bank.
`timescale 1ns/1ps
module wfs_host_model (
    // Clock
    input wire logic              sys_clk,
    // Transfers toward the bank
    output wfs_pkg::wfs_reg_req_t reg_req
);
    import wfs_pkg::*;
    initial reg_req = '0;
    // One transfer after an idle gap; released fields show inverted values so stale data is never trusted.
    task automatic xfer(input logic rd, input logic wr, input logic [7:0] a, input logic [7:0] d,
                        input logic v, input int gap);
        repeat (gap) @(negedge sys_clk);
        @(negedge sys_clk);
        reg_req = '{1'b1, v, rd, wr, a, d};
        @(negedge sys_clk);
        reg_req = '{1'b0, 1'b0, 1'b0, 1'b0, ~a, ~d};
    endtask : xfer
endmodule : wfs_host_model
